// ===== src/opstat_pkg.sv
// Package with register map, field positions and carrier types for operation status.
package opstat_pkg;

  // ---------------------------------------------------------------------------
  // Register selection codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_CONDITION = 3'h0;
  localparam logic [2:0] SEL_EVENT     = 3'h1;
  localparam logic [2:0] SEL_ENABLE    = 3'h2;
  localparam logic [2:0] SEL_RISE_FILT = 3'h3;
  localparam logic [2:0] SEL_FALL_FILT = 3'h4;

  // ---------------------------------------------------------------------------
  // Condition bit positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CURRENT_SOURCE_AUTO_BIT = 7;
  localparam int INPUT_OVERVOLTAGE_BIT   = 8;
  localparam int OUTPUT_OVERVOLTAGE_BIT  = 9;
  localparam int CONFIG_MEMORY_BUSY_BIT  = 10;
  localparam int SELFTEST_RUNNING_BIT    = 12;
  localparam int SUMMARY_STB_BIT         = 7;
  localparam logic [15:0] USED_BITS_MASK = 16'h1780;
  localparam logic [15:0] REG_RESET      = 16'h0000;

  // Register access request from the command parser.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [15:0] wdata;
  } reg_req_type;

  // Live instrument state inputs.
  typedef struct packed {
    logic selftest_running;
    logic config_memory_busy;
    logic output_overvoltage;
    logic input_overvoltage;
    logic current_source_auto_running;
  } inst_state_type;

endpackage

// ===== src/operation_status_reporting.sv
// Operation status condition, transition filter, event and enable logic.
`timescale 1ns/1ps
`default_nettype none

module operation_status_reporting
  import opstat_pkg::*;
(
  input  wire logic           CLK,
  input  wire logic           RST,
  input  wire inst_state_type STATE,
  input  wire reg_req_type    REQ,
  input  wire logic           CLEAR_STATUS,
  output logic [15:0]         RDATA,
  output logic                RVALID,
  output logic [7:0]          STB_CONTRIB,
  output logic                OPERATION_SUMMARY
);

  // ---------------------------------------------------------------------------
  // Condition assembly
  // ---------------------------------------------------------------------------

  // Condition is purely combinational from live inputs, so no history is kept.
  logic [15:0] condition_raw;
  always_comb begin
    condition_raw = 16'h0000;
    condition_raw[SELFTEST_RUNNING_BIT]    = STATE.selftest_running;
    condition_raw[CURRENT_SOURCE_AUTO_BIT] = STATE.current_source_auto_running;
    condition_raw[CONFIG_MEMORY_BUSY_BIT]  = STATE.config_memory_busy;
    condition_raw[OUTPUT_OVERVOLTAGE_BIT]  = STATE.output_overvoltage;
    condition_raw[INPUT_OVERVOLTAGE_BIT]   = STATE.input_overvoltage;
  end

  // Mask keeps unused positions at zero even if the assembly above is edited.
  wire logic [15:0] operation_condition = condition_raw & USED_BITS_MASK;

  // ---------------------------------------------------------------------------
  // Transition detection
  // ---------------------------------------------------------------------------

  // Previous condition sample; reset value zero means a condition already
  // active out of reset is seen as a rising edge on the first cycle.
  logic [15:0] cond_prev_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cond_prev_q <= REG_RESET;
    end else begin
      cond_prev_q <= operation_condition;
    end
  end

  logic [15:0] rising_edge_filter_q;
  logic [15:0] falling_edge_filter_q;

  // Each bit qualifies on the edge its own filters select.
  wire logic [15:0] rose      = operation_condition & ~cond_prev_q;
  wire logic [15:0] fell      = ~operation_condition & cond_prev_q;
  wire logic [15:0] new_event = (rose & rising_edge_filter_q) |
                                (fell & falling_edge_filter_q);

  // ---------------------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------------------
  wire logic rd_event  = REQ.rd && (REQ.sel == SEL_EVENT);
  wire logic wr_enable = REQ.wr && (REQ.sel == SEL_ENABLE);
  wire logic wr_rise   = REQ.wr && (REQ.sel == SEL_RISE_FILT);
  wire logic wr_fall   = REQ.wr && (REQ.sel == SEL_FALL_FILT);
  wire logic clr_event = rd_event || CLEAR_STATUS;

  // ---------------------------------------------------------------------------
  // Event, enable and filter registers
  // ---------------------------------------------------------------------------
  logic [15:0] event_q;
  logic [15:0] event_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [15:0] rise_d;
  logic [15:0] fall_d;

  // New events are OR-ed after the clear, so a coincident edge is never lost.
  always_comb begin
    event_d = clr_event ? REG_RESET : event_q;
    event_d = event_d | new_event;
  end

  // Enable only changes on its own write; nothing else touches it.
  assign enable_d = wr_enable ? REQ.wdata : enable_q;
  assign rise_d   = wr_rise ? REQ.wdata : rising_edge_filter_q;
  assign fall_d   = wr_fall ? REQ.wdata : falling_edge_filter_q;

  // Power-on state clears event, enable and both filters.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      event_q               <= REG_RESET;
      enable_q              <= REG_RESET;
      rising_edge_filter_q  <= REG_RESET;
      falling_edge_filter_q <= REG_RESET;
    end else begin
      event_q               <= event_d;
      enable_q              <= enable_d;
      rising_edge_filter_q  <= rise_d;
      falling_edge_filter_q <= fall_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------------------

  // Values are plain binary, so the decimal weight sum is the number itself.
  logic [15:0] rdata_mux;
  always_comb begin
    case (REQ.sel)
      SEL_CONDITION: rdata_mux = operation_condition;
      SEL_EVENT:     rdata_mux = event_q;
      SEL_ENABLE:    rdata_mux = enable_q;
      SEL_RISE_FILT: rdata_mux = rising_edge_filter_q;
      SEL_FALL_FILT: rdata_mux = falling_edge_filter_q;
      default:       rdata_mux = 16'h0000;
    endcase
  end

  // Read data is registered; the event value captured is the pre-clear one.
  logic [15:0] rdata_q;
  logic        rvalid_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= REQ.rd ? rdata_mux : rdata_q;
      rvalid_q <= REQ.rd;
    end
  end

  // ---------------------------------------------------------------------------
  // Summary bit
  // ---------------------------------------------------------------------------

  // Registered from event_d and enable_d, so the summary tracks event_q and enable_q with no lag.
  logic summary_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(event_d & enable_d);
    end
  end

  assign RDATA             = rdata_q;
  assign RVALID            = rvalid_q;
  assign OPERATION_SUMMARY = summary_q;
  assign STB_CONTRIB       = {summary_q, 7'h00} & (8'h01 << SUMMARY_STB_BIT);

endmodule

`default_nettype wire

// ===== tb/opstat_host.sv
// Remote host model issuing register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module opstat_host
  import opstat_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RVALID,
  input  wire logic [15:0] RDATA,
  output var reg_req_type  REQ
);
  // Idle request until a transfer is asked for.
  initial REQ = '0;
  // One strobe cycle carrying a 16-bit weight sum; a gap edge follows.
  task automatic wr(input logic [2:0] sel, input logic [15:0] wd);
    @(posedge CLK) REQ <= '{1'b1, 1'b0, sel, wd};
    @(posedge CLK) REQ <= '0;
  endtask
  // The answer stands for the one cycle after the strobe edge.
  task automatic rd(input logic [2:0] sel, output logic [15:0] rd_d, output logic rd_v);
    @(posedge CLK) REQ <= '{1'b0, 1'b1, sel, 16'h0000};
    @(posedge CLK) REQ <= '0;
    #1 rd_d = RDATA;
    rd_v = RVALID;
  endtask
endmodule
`default_nettype wire

// ===== tb/opstat_properties.sv
// Checker of operation status port behaviour.
`timescale 1ns/1ps
`default_nettype none
module opstat_properties
  import opstat_pkg::*;
(
  input wire logic           CLK,
  input wire logic           RST,
  input wire inst_state_type STATE,
  input wire reg_req_type    REQ,
  input wire logic           CLEAR_STATUS,
  input wire logic [15:0]    RDATA,
  input wire logic           RVALID,
  input wire logic [7:0]     STB_CONTRIB,
  input wire logic           OPERATION_SUMMARY
);
  // Expected condition word from the packed state bits.
  wire [15:0] cond_w = {3'h0, STATE[4], 1'h0, STATE[3:0], 7'h00};
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Answers, clears and summary moves are tied to their causes.
  rvalid_pulse_a: assert property (RVALID == $past(REQ.rd))
    else $error("read answer misplaced");
  summary_bit_a: assert property (STB_CONTRIB == {OPERATION_SUMMARY, 7'h00})
    else $error("status bit wrong");
  cond_value_a: assert property (
    REQ.rd && REQ.sel == SEL_CONDITION && $stable(STATE) |=> RDATA == $past(cond_w))
    else $error("condition word wrong");
  enable_zero_a: assert property (
    REQ.wr && REQ.sel == SEL_ENABLE && REQ.wdata == 16'h0000 |=> !OPERATION_SUMMARY)
    else $error("summary kept after mask cleared");
  clear_status_a: assert property (
    CLEAR_STATUS && $stable(STATE) && !$past(RST) |=> !OPERATION_SUMMARY)
    else $error("summary kept after clear");
  read_clears_a: assert property (
    (REQ.rd && REQ.sel == SEL_EVENT && $stable(STATE) && !$past(RST)) ##1 $stable(STATE)
    ##1 (REQ.rd && REQ.sel == SEL_EVENT && $stable(STATE)) |=> RDATA == 16'h0000)
    else $error("event word not cleared by read");
  summary_rise_a: assert property ($rose(OPERATION_SUMMARY) |->
    $past(STATE) != $past(STATE, 2) || $past(REQ.wr) || $past(RST, 2))
    else $error("summary rose without cause");
  summary_fall_a: assert property ($fell(OPERATION_SUMMARY) |->
    $past(REQ.rd || REQ.wr || CLEAR_STATUS)) else $error("summary fell without cause");
endmodule
bind operation_status_reporting opstat_properties u_props (.CLK, .RST, .STATE, .REQ,
  .CLEAR_STATUS, .RDATA, .RVALID, .STB_CONTRIB, .OPERATION_SUMMARY);
`default_nettype wire

// ===== tb/tb_operation_status_reporting.sv
// Self-checking bench for operation status reporting.
`timescale 1ns/1ps
`default_nettype none
module tb_operation_status_reporting import opstat_pkg::*; ;
  logic CLK = 0, RST = 1, CLEAR_STATUS = 0, RVALID, sum, v;
  inst_state_type STATE = '0;
  reg_req_type REQ;
  logic [15:0] RDATA, d, r, f, e, ev;
  logic [7:0] stb;
  logic [4:0] so, sn;
  int n_errors = 0, check_count = 0;
  // Free-running 125 MHz clock.
  always #4 CLK = ~CLK;
  operation_status_reporting u_dut (.CLK, .RST, .STATE, .REQ, .CLEAR_STATUS, .RDATA,
    .RVALID, .STB_CONTRIB(stb), .OPERATION_SUMMARY(sum));
  opstat_host u_host (.CLK, .RVALID, .RDATA, .REQ);
  // Expected words; events come from both filters against old and new condition.
  function automatic logic [15:0] cond_of(logic [4:0] s);
    return {3'h0, s[4], 1'h0, s[3:0], 7'h00};
  endfunction
  function automatic logic [15:0] ev_of(logic [15:0] a, b, rf, ff);
    return (rf & ~a & b) | (ff & a & ~b);
  endfunction
  // Compare, read-and-compare, and the verdict.
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(string nm, logic [2:0] sel, logic [15:0] exp);
    u_host.rd(sel, d, v);
    chk("answer strobe", 16'h0001, {15'h0000, v});
    chk(nm, exp, d);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard well beyond the expected run of about 670 cycles.
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    conclude();
  end
  // First four passes set each filter mode with all bits enabled; the rest are random.
  initial begin
    void'($urandom(14045));
    repeat (8) @(posedge CLK);
    RST <= 0;
    for (int s = 1; s <= 4; s++) rdc("reset value", 3'(s), REG_RESET);
    rdc("unmapped", 3'h7, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      r = (i < 4) ? {16{i[0]}} : 16'($urandom);
      f = (i < 4) ? {16{i[1]}} : 16'($urandom);
      e = (i < 4) ? 16'hffff : 16'($urandom);
      so = 5'($urandom);
      sn = (i < 4) ? ~so : 5'($urandom);
      u_host.wr(SEL_RISE_FILT, r);
      u_host.wr(SEL_FALL_FILT, f);
      u_host.wr(SEL_ENABLE, e);
      rdc("rise filter", SEL_RISE_FILT, r);
      rdc("fall filter", SEL_FALL_FILT, f);
      rdc("enable", SEL_ENABLE, e);
      @(posedge CLK) STATE <= so;
      repeat (2) @(posedge CLK);
      u_host.rd(SEL_EVENT, d, v);
      @(posedge CLK) STATE <= sn;
      repeat (2) @(posedge CLK);
      ev = ev_of(cond_of(so), cond_of(sn), r, f);
      #1 chk("summary", {15'h0000, |(ev & e)}, {15'h0000, sum});
      // Odd passes clear by command while events are still latched.
      if (i[0]) begin
        @(posedge CLK) CLEAR_STATUS <= 1'b1;
        @(posedge CLK) CLEAR_STATUS <= 1'b0;
        ev = 16'h0000;
      end
      rdc("event", SEL_EVENT, ev);
      rdc("cleared event", SEL_EVENT, 16'h0000);
      rdc("condition", SEL_CONDITION, cond_of(sn));
      chk("summary off", 16'h0000, {15'h0000, sum});
      $display("test %0d done", i);
    end
    u_host.wr(SEL_ENABLE, 16'h0000);
    rdc("enable zero", SEL_ENABLE, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
